/* logic/txdq_pkg.sv */
package txdq_pkg;
  // Register map and reset values.
  localparam logic [11:0] TXDQ_ADDR_FLUSH_TMR = 12'h844;
  localparam logic [11:0] TXDQ_ADDR_QCTRL = 12'h880;
  localparam logic [15:0] TXDQ_FLUSH_TMR_RST = 16'h0000;
  localparam logic [15:0] TXDQ_QCTRL_RST = 16'h0000;
  localparam logic [15:0] TXDQ_QCTRL_MASK = 16'h071b;
  // Queue control fields.
  localparam int TXDQ_PEND_BURST_BIT = 0;
  localparam int TXDQ_PEND_FLUSH_BIT = 1;
  localparam int TXDQ_DONE_BURST_BIT = 3;
  localparam int TXDQ_DONE_FLUSH_BIT = 4;
  localparam int TXDQ_THR_LSB = 8;
  localparam int TXDQ_THR_W = 3;
  // Timer and buffer sizing.
  localparam int TXDQ_PRESCALE = 256;
  localparam int TXDQ_TMR_W = 16;
  localparam logic [15:0] TXDQ_TMR_MAX_CODE = 16'hffff;
  localparam logic [16:0] TXDQ_TMR_MAX_CNT = 17'h10000;
  localparam int TXDQ_FIFO_DEPTH = 8;
  localparam int TXDQ_HIGH_WATER = 6;
  localparam int TXDQ_CHANS = 256;
  localparam int TXDQ_DWORDS = 6;
  // Channel configuration dword 1 fields, the dword 2 start pointer and the host word select.
  localparam int TXDQ_CHANNEL_ENABLE_FLAG_BIT = 0;
  localparam int TXDQ_DQS_BIT = 1;
  localparam int TXDQ_BCNT_LSB = 3;
  localparam int TXDQ_BCNT_W = 13;
  localparam int TXDQ_CV_BIT = 16;
  localparam int TXDQ_EOF_BIT = 17;
  localparam int TXDQ_PEND_LSB = 18;
  localparam int TXDQ_PRI_LSB = 20;
  localparam int TXDQ_PPP_BIT = 22;
  localparam int TXDQ_START_PTR_LSB = 16;
  localparam logic [3:0] TXDQ_WSEL_D1_LO = 4'h2;
  // Done entry status codes.
  localparam logic [2:0] TXDQ_ST_PACKET = 3'h0;
  localparam logic [2:0] TXDQ_ST_FIRST = 3'h1;
  localparam logic [2:0] TXDQ_ST_MIDDLE = 3'h2;
  localparam logic [2:0] TXDQ_ST_LAST = 3'h3;
  localparam logic [2:0] TXDQ_ST_NOT_ENABLED = 3'h4;

  // One done-queue dword as written to host memory.
  typedef struct packed {
    logic [2:0] unused;
    logic [2:0] status;
    logic prio;
    logic channel_restart_flag;
    logic [7:0] chan;
    logic [15:0] ptr;
  } txdq_entry_t;

  // Buffer completion report from the transmit engine.
  typedef struct packed {
    logic [7:0] chan;
    logic [15:0] desc_ptr;
    logic first;
    logic last;
    logic [2:0] err;
  } txdq_bufdone_t;

  // DMA working-state write into the configuration RAM.
  typedef struct packed {
    logic [7:0] chan;
    logic [2:0] dword;
    logic [31:0] data;
  } txdq_cfgwr_t;
endpackage

/* logic/txdq_engine.sv */
`timescale 1ns/1ns
module txdq_engine
  import txdq_pkg::*;
#(
  parameter int CHANS = TXDQ_CHANS,
  parameter int FIFO_DEPTH = TXDQ_FIFO_DEPTH,
  parameter int HIGH_WATER = TXDQ_HIGH_WATER
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [7:0] cfg_chan,
  input wire logic [3:0] cfg_wsel,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  input wire logic dma_cfg_wr,
  input wire txdq_cfgwr_t dma_cfg,
  input wire logic chan_restart,
  input wire logic [7:0] chan_restart_id,
  input wire logic bd_valid,
  input wire txdq_bufdone_t bd,
  output logic bd_ready,
  input wire logic [15:0] dq_room,
  output logic dq_wr_valid,
  output logic [31:0] dq_wr_data,
  output logic dq_wr_last,
  input wire logic dq_wr_ready,
  output logic done_write_status,
  output logic done_write_error
);
  localparam int MEM_W = 11;
  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam int PRE_W = $clog2(TXDQ_PRESCALE);

  typedef enum logic {TXDQ_W_IDLE, TXDQ_W_BURST} txdq_wstate_t;

  // Linear RAM index of one dword of one channel.
  function automatic logic [MEM_W-1:0] txdq_idx(input logic [7:0] chan, input logic [2:0] dw);
    txdq_idx = MEM_W'(chan) * MEM_W'(TXDQ_DWORDS) + MEM_W'(dw);
  endfunction

  logic [15:0] flush_tmr_r;
  logic [15:0] qctrl_r;
  logic [PRE_W-1:0] pre_r;
  logic [16:0] tmr_r;
  logic [16:0] reload_cnt;
  logic tick;
  logic burst_en;
  logic flush_on;
  logic tmr_expired;
  logic [31:0] cfg_mem [0:CHANS*TXDQ_DWORDS-1];
  logic [31:0] bd_d1;
  logic [31:0] bd_d2;
  logic [2:0] err_eff;
  logic post;
  txdq_entry_t new_entry;
  logic [31:0] fifo_mem [0:FIFO_DEPTH-1];
  logic [PTR_W-1:0] wp_r;
  logic [PTR_W-1:0] rp_r;
  logic [CNT_W-1:0] count_r;
  logic push;
  logic pop;
  logic go;
  logic drop_all;
  logic [CNT_W-1:0] burst_len;
  txdq_wstate_t wst_r;
  logic [CNT_W-1:0] burst_left_r;
  logic burst_end;
  logic [7:0] thr_cnt_r;
  logic [8:0] thr_target;
  logic [8:0] thr_cnt_nxt;

  assign burst_en = qctrl_r[TXDQ_DONE_BURST_BIT];
  assign flush_on = qctrl_r[TXDQ_DONE_FLUSH_BIT];
  assign tick = (pre_r == PRE_W'(TXDQ_PRESCALE - 1));
  assign tmr_expired = burst_en && (tmr_r == 17'h00000);

  // Register writes; reserved control bits stay zero.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flush_tmr_r <= TXDQ_FLUSH_TMR_RST;
      qctrl_r <= TXDQ_QCTRL_RST;
    end else if (reg_wr) begin
      if (reg_addr == TXDQ_ADDR_FLUSH_TMR) begin
        flush_tmr_r <= reg_wdata;
      end
      if (reg_addr == TXDQ_ADDR_QCTRL) begin
        qctrl_r <= reg_wdata & TXDQ_QCTRL_MASK;
      end
    end
  end

  // Register reads answer one cycle later; unmapped reads give zero.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == TXDQ_ADDR_FLUSH_TMR) begin
        reg_rdata <= flush_tmr_r;
      end else if (reg_addr == TXDQ_ADDR_QCTRL) begin
        reg_rdata <= qctrl_r;
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // The reload code maps to its own count, the top code to the full range.
  assign reload_cnt = (flush_tmr_r == TXDQ_TMR_MAX_CODE) ? TXDQ_TMR_MAX_CNT : {1'b0, flush_tmr_r};

  // Free-running divide-by-256 prescaler for the flush timer.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + PRE_W'(1);
    end
  end

  // Flush timer: held at the reload value unless burst mode watches it.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tmr_r <= 17'h00000;
    end else if (!burst_en) begin
      tmr_r <= reload_cnt;
    end else if (burst_end || (tmr_expired && wst_r == TXDQ_W_IDLE)) begin
      tmr_r <= reload_cnt;
    end else if (tick && tmr_r != 17'h00000) begin
      tmr_r <= tmr_r - 17'h00001;
    end
  end

  // Configuration lookup for the reporting channel.
  assign bd_d1 = cfg_mem[txdq_idx(bd.chan, 3'h1)];
  assign bd_d2 = cfg_mem[txdq_idx(bd.chan, 3'h2)];

  // Build the done entry from the buffer report and channel settings.
  always_comb begin
    err_eff = bd.err;
    if (bd.err == 3'h0 && !bd_d1[TXDQ_CHANNEL_ENABLE_FLAG_BIT]) begin
      err_eff = TXDQ_ST_NOT_ENABLED;
    end
    post = (err_eff != 3'h0) || bd_d1[TXDQ_DQS_BIT] || bd.last;
    new_entry = '0;
    new_entry.chan = bd.chan;
    if (bd_d1[TXDQ_DQS_BIT]) begin
      new_entry.ptr = bd.desc_ptr;
    end else begin
      new_entry.ptr = bd_d2[TXDQ_START_PTR_LSB +: 16];
    end
    if (err_eff != 3'h0) begin
      new_entry.status = err_eff;
    end else if (!bd_d1[TXDQ_DQS_BIT]) begin
      new_entry.status = TXDQ_ST_PACKET;
    end else if (bd.first) begin
      new_entry.status = TXDQ_ST_FIRST;
    end else if (bd.last) begin
      new_entry.status = TXDQ_ST_LAST;
    end else begin
      new_entry.status = TXDQ_ST_MIDDLE;
    end
  end

  // Configuration RAM: DMA state writes, the one host word, then enable updates.
  always_ff @(posedge ref_clk) begin
    if (dma_cfg_wr) begin
      cfg_mem[txdq_idx(dma_cfg.chan, dma_cfg.dword)] <= dma_cfg.data;
    end
    if (cfg_wr && cfg_wsel == TXDQ_WSEL_D1_LO) begin
      cfg_mem[txdq_idx(cfg_chan, 3'h1)][15:0] <= cfg_wdata;
    end
    if (chan_restart) begin
      cfg_mem[txdq_idx(chan_restart_id, 3'h1)][TXDQ_CHANNEL_ENABLE_FLAG_BIT] <= 1'b1;
    end
    if (bd_valid && bd_ready && err_eff != 3'h0) begin
      cfg_mem[txdq_idx(bd.chan, 3'h1)][TXDQ_CHANNEL_ENABLE_FLAG_BIT] <= 1'b0;
    end
  end

  // Host view of the RAM, one 16-bit half per word select.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_rdata <= 16'h0000;
    end else if (cfg_rd) begin
      if (cfg_wsel[0]) begin
        cfg_rdata <= cfg_mem[txdq_idx(cfg_chan, cfg_wsel[3:1])][31:16];
      end else begin
        cfg_rdata <= cfg_mem[txdq_idx(cfg_chan, cfg_wsel[3:1])][15:0];
      end
    end
  end

  // Done-descriptor buffer handshakes.
  assign bd_ready = (count_r != CNT_W'(FIFO_DEPTH));
  assign push = bd_valid && bd_ready && post;
  assign pop = dq_wr_valid && dq_wr_ready;
  assign dq_wr_valid = (wst_r == TXDQ_W_BURST);
  assign dq_wr_data = fifo_mem[rp_r];
  assign dq_wr_last = (burst_left_r == CNT_W'(1));
  assign burst_end = pop && dq_wr_last;

  // Start a write: singly without burst mode, else at high water, flush or expiry.
  always_comb begin
    go = 1'b0;
    if (wst_r == TXDQ_W_IDLE && count_r != '0) begin
      go = !burst_en || (count_r >= CNT_W'(HIGH_WATER)) || flush_on || tmr_expired;
    end
    drop_all = go && (dq_room == 16'h0000) && burst_en;
    if (!burst_en) begin
      burst_len = CNT_W'(1);
    end else if ({12'h000, count_r} > dq_room) begin
      burst_len = CNT_W'(dq_room);
    end else begin
      burst_len = count_r;
    end
  end

  // Buffer storage.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      fifo_mem[wp_r] <= new_entry;
    end
  end

  // Buffer pointers; a refused write discards what it could not place.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + PTR_W'(1);
      end
      if (drop_all) begin
        rp_r <= wp_r;
        count_r <= push ? CNT_W'(1) : '0;
      end else if (go && dq_room == 16'h0000) begin
        rp_r <= rp_r + PTR_W'(1);
        count_r <= push ? count_r : count_r - CNT_W'(1);
      end else begin
        if (pop) begin
          rp_r <= rp_r + PTR_W'(1);
        end
        count_r <= count_r + CNT_W'(push) - CNT_W'(pop);
      end
    end
  end

  // Writer state: idle, or walking a burst of known length.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wst_r <= TXDQ_W_IDLE;
      burst_left_r <= '0;
    end else begin
      unique case (wst_r)
        TXDQ_W_IDLE: begin
          if (go && dq_room != 16'h0000) begin
            wst_r <= TXDQ_W_BURST;
            burst_left_r <= burst_len;
          end
        end
        TXDQ_W_BURST: begin
          if (pop) begin
            burst_left_r <= burst_left_r - CNT_W'(1);
            if (dq_wr_last) begin
              wst_r <= TXDQ_W_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Write error pulse when no slot is free.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      done_write_error <= 1'b0;
    end else begin
      done_write_error <= go && (dq_room == 16'h0000);
    end
  end

  // Status threshold: 1, 2, 4 ... 128 writes since the last status pulse.
  assign thr_target = 9'h001 << qctrl_r[TXDQ_THR_LSB +: TXDQ_THR_W];
  assign thr_cnt_nxt = {1'b0, thr_cnt_r} + 9'h001;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      thr_cnt_r <= 8'h00;
      done_write_status <= 1'b0;
    end else begin
      done_write_status <= 1'b0;
      if (pop) begin
        if (thr_cnt_nxt >= thr_target) begin
          thr_cnt_r <= 8'h00;
          done_write_status <= 1'b1;
        end else begin
          thr_cnt_r <= thr_cnt_nxt[7:0];
        end
      end
    end
  end

  a_tmr_decrement: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (burst_en && tick && tmr_r != 17'h00000 && !burst_end && !$changed(qctrl_r) && !reg_wr)
      |=> (tmr_r == $past(tmr_r) - 17'h00001))
    else $error("flush timer did not step down on the prescaler tick");

  a_tmr_idle_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!burst_en && !reg_wr) |=> (tmr_r == $past(reload_cnt)) && !$past(tmr_expired))
    else $error("flush timer moved while burst mode was off");

  a_reload_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (burst_end && !reg_wr) |=> (tmr_r == $past(reload_cnt)))
    else $error("flush timer not reloaded after a done-queue write");

  a_expiry_burst: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wst_r == TXDQ_W_IDLE && tmr_expired && count_r != '0 && dq_room != 16'h0000)
      |=> dq_wr_valid ##0 (burst_left_r == $past(burst_len)))
    else $error("timer expiry did not start a burst");

  a_single_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wst_r == TXDQ_W_IDLE && go && !burst_en && dq_room != 16'h0000)
      |=> dq_wr_last throughout (dq_wr_valid [*1]))
    else $error("non-burst mode wrote more than one descriptor");

  a_high_water: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wst_r == TXDQ_W_IDLE && count_r >= CNT_W'(HIGH_WATER) && dq_room != 16'h0000) |=> dq_wr_valid)
    else $error("high water mark did not start a burst");

  a_full_refuse: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (count_r == CNT_W'(FIFO_DEPTH)) |-> !bd_ready)
    else $error("full buffer accepted a descriptor");

  a_no_room: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (go && dq_room == 16'h0000) |=> done_write_error && !dq_wr_valid)
    else $error("no-room case wrote or missed the error");

  a_flush_drain: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (flush_on && wst_r == TXDQ_W_IDLE && count_r != '0 && dq_room != 16'h0000) |=> dq_wr_valid)
    else $error("flush bit did not drain the buffer");

  a_status_thr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (pop && qctrl_r[TXDQ_THR_LSB +: TXDQ_THR_W] == 3'h0) |=> done_write_status && (thr_cnt_r == 8'h00))
    else $error("threshold zero did not raise status per write");
endmodule

/* verif/txdq_host_mem.sv */
`timescale 1ns/1ns
// Host side of the done queue: free-slot report, ready with stalls, and a count of accepted dwords with the last one.
module txdq_host_mem (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic dq_wr_valid,
  input wire logic [31:0] dq_wr_data,
  output logic dq_wr_ready,
  output logic [15:0] dq_room,
  input wire logic [15:0] room_set,
  input wire logic stall_en,
  output logic [15:0] rx_cnt,
  output logic [31:0] rx_data
);
  // Free slots as the bench sets them on room_set; zero means the queue is full.
  assign dq_room = room_set;
  // Ready drops at random when stalls are on; accepted dwords are counted and only the last one is kept.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dq_wr_ready <= 1'h1;
      rx_cnt <= 16'h0;
      rx_data <= 32'h0;
    end else begin
      dq_wr_ready <= stall_en ? 1'($urandom % 2) : 1'h1;
      if (dq_wr_valid && dq_wr_ready) begin
        rx_cnt <= rx_cnt + 16'h1;
        rx_data <= dq_wr_data;
      end
    end
  end
endmodule

/* verif/txdq_engine_bench.sv */
`timescale 1ns/1ns
module txdq_engine_bench;
  import txdq_pkg::*;
  logic ref_clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, cfg_wr = 1'h0, cfg_rd = 1'h0;
  logic dma_cfg_wr = 1'h0, chan_restart = 1'h0, bd_valid = 1'h0, stall_en = 1'h1;
  logic [11:0] reg_addr = 12'h0;
  logic [15:0] reg_wdata = 16'h0, cfg_wdata = 16'h0, room_set = 16'h40, q, p, reg_rdata, cfg_rdata, dq_room, rx_cnt;
  logic [7:0] cfg_chan = 8'h0, chan_restart_id = 8'h0, ch = 8'h0;
  logic [3:0] cfg_wsel = 4'h0;
  logic [31:0] w, dq_wr_data, rx_data;
  logic bd_ready, dq_wr_valid, dq_wr_last, dq_wr_ready, done_write_status, done_write_error;
  txdq_cfgwr_t dma_cfg = '0;
  txdq_bufdone_t bd = '0;
  int mismatches = 0, num_checks = 0, cyc = 0, n_st = 0, n_er = 0, n = 0, n_ls = 0;

  txdq_engine i_dut (.ref_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .cfg_chan,
    .cfg_wsel, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata, .dma_cfg_wr, .dma_cfg, .chan_restart,
    .chan_restart_id, .bd_valid, .bd, .bd_ready, .dq_room, .dq_wr_valid, .dq_wr_data, .dq_wr_last,
    .dq_wr_ready, .done_write_status, .done_write_error);
  txdq_host_mem i_host (.ref_clk, .sys_rst, .dq_wr_valid, .dq_wr_data, .dq_wr_ready, .dq_room,
    .room_set, .stall_en, .rx_cnt, .rx_data);

  // Clock, status pulse counters and the hang limit.
  always #10 ref_clk = !ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    n_st += int'(done_write_status === 1'h1);
    n_er += int'(done_write_error === 1'h1);
    n_ls += int'(dq_wr_valid === 1'h1 && dq_wr_ready === 1'h1 && dq_wr_last === 1'h1);
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Register port write or read; read data is taken at the falling edge after the edge that samples the read.
  task automatic rg(input logic [11:0] a, input logic wr, input logic [15:0] d, output logic [15:0] r);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    @(negedge ref_clk);
    r = reg_rdata;
  endtask

  // Host access to the current channel's configuration words.
  task automatic cf(input logic [3:0] s, input logic wr, input logic [15:0] d, output logic [15:0] r);
    @(posedge ref_clk);
    cfg_chan <= ch;
    cfg_wsel <= s;
    cfg_wdata <= d;
    cfg_wr <= wr;
    cfg_rd <= !wr;
    @(posedge ref_clk);
    cfg_wr <= 1'h0;
    cfg_rd <= 1'h0;
    @(negedge ref_clk);
    r = cfg_rdata;
  endtask

  // Engine-side full dword write into the configuration RAM.
  task automatic dmaw(input logic [2:0] d, input logic [31:0] v);
    @(posedge ref_clk);
    dma_cfg_wr <= 1'h1;
    dma_cfg <= '{ch, d, v};
    @(posedge ref_clk);
    dma_cfg_wr <= 1'h0;
  endtask

  // One buffer report with a fresh random pointer, held until ready is seen.
  task automatic push(input logic f, input logic l, input logic [2:0] e);
    int k;
    k = 0;
    p = 16'($urandom);
    @(posedge ref_clk);
    bd_valid <= 1'h1;
    bd <= '{ch, p, f, l, e};
    @(negedge ref_clk);
    while (bd_ready !== 1'h1 && k < 200) begin
      @(negedge ref_clk);
      k++;
    end
    @(posedge ref_clk);
    bd_valid <= 1'h0;
  endtask

  // Waits, bounded, for the host log to reach an expected dword count.
  task automatic wrx(input int c);
    int k;
    k = 0;
    while (rx_cnt < 16'(c) && k < 400) begin
      @(negedge ref_clk);
      k++;
    end
    chk({16'h0, rx_cnt}, 32'(c));
  endtask

  // Expected done-queue dword and per-buffer status code.
  function automatic logic [31:0] ent(input logic [2:0] s, input logic [15:0] ptr);
    ent = {3'h0, s, 2'h0, ch, ptr};
  endfunction
  function automatic logic [2:0] sx(input logic f, input logic l);
    sx = f ? TXDQ_ST_FIRST : (l ? TXDQ_ST_LAST : TXDQ_ST_MIDDLE);
  endfunction

  // Main sequence.
  initial begin
    void'($urandom(10026));
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'h0;
    // Register reset values, unmapped and reserved bits, reload read-back.
    rg(TXDQ_ADDR_FLUSH_TMR, 1'h0, 16'h0, q);
    chk(q, TXDQ_FLUSH_TMR_RST);
    rg(TXDQ_ADDR_QCTRL, 1'h0, 16'h0, q);
    chk(q, TXDQ_QCTRL_RST);
    rg(12'h800, 1'h0, 16'h0, q);
    chk(q, 32'h0);
    rg(TXDQ_ADDR_QCTRL, 1'h1, 16'hf8e4, q);
    rg(TXDQ_ADDR_QCTRL, 1'h0, 16'h0, q);
    chk(q, 32'h0);
    w = 32'($urandom) | 32'h1;
    rg(TXDQ_ADDR_FLUSH_TMR, 1'h1, w[15:0], q);
    rg(TXDQ_ADDR_FLUSH_TMR, 1'h0, 16'h0, q);
    chk(q, w[15:0]);
    // Every dword of one channel, both halves, then a refused host write.
    ch = 8'($urandom);
    for (int d = 0; d < 6; d++) begin
      w = $urandom;
      dmaw(3'(d), w);
      cf(4'(2 * d), 1'h0, 16'h0, q);
      chk(q, w[15:0]);
      cf(4'(2 * d + 1), 1'h0, 16'h0, q);
      chk(q, w[31:16]);
    end
    cf(4'h3, 1'h0, 16'h0, q);
    p = q;
    cf(4'h3, 1'h1, ~p, q);
    cf(4'h3, 1'h0, 16'h0, q);
    chk(q, p);
    // Single writes per buffer with every position code.
    cf(4'h2, 1'h1, 16'h0003, q);
    n_st = 0;
    for (int i = 0; i < 4; i++) begin
      push(i[0], i[1], 3'h0);
      n++;
      wrx(n);
      chk(rx_data, ent(sx(i[0], i[1]), p));
    end
    repeat (4) @(negedge ref_clk);
    chk(n_st, 4);
    // Per-packet mode posts only at the end, with the start pointer.
    cf(4'h2, 1'h1, 16'h0001, q);
    w = $urandom;
    dmaw(3'h2, w);
    push(1'h1, 1'h0, 3'h0);
    repeat (20) @(negedge ref_clk);
    wrx(n);
    push(1'h0, 1'h1, 3'h0);
    n++;
    wrx(n);
    chk(rx_data, ent(TXDQ_ST_PACKET, w[31:16]));
    // An error disables the channel, a disabled channel reports 100, restart re-enables.
    cf(4'h2, 1'h1, 16'h0003, q);
    push(1'h1, 1'h1, 3'h6);
    n++;
    wrx(n);
    chk(rx_data, ent(3'h6, p));
    cf(4'h2, 1'h0, 16'h0, q);
    chk(q[0], 1'h0);
    push(1'h1, 1'h1, 3'h0);
    n++;
    wrx(n);
    chk(rx_data, ent(TXDQ_ST_NOT_ENABLED, p));
    @(posedge ref_clk);
    chan_restart <= 1'h1;
    chan_restart_id <= ch;
    @(posedge ref_clk);
    chan_restart <= 1'h0;
    cf(4'h2, 1'h0, 16'h0, q);
    chk(q[0], 1'h1);
    // No room: error pulse and nothing written.
    @(posedge ref_clk);
    room_set <= 16'h0;
    n_er = 0;
    push(1'h1, 1'h1, 3'h0);
    repeat (10) @(negedge ref_clk);
    chk({16'h0, rx_cnt}, 32'(n));
    chk(n_er, 1);
    @(posedge ref_clk);
    room_set <= 16'h40;
    // Every threshold code, twice its count of writes gives two pulses.
    for (int t = 0; t < 8; t++) begin
      rg(TXDQ_ADDR_QCTRL, 1'h1, 16'(t << TXDQ_THR_LSB), q);
      n_st = 0;
      repeat (2 << t) begin
        push(1'h1, 1'h1, 3'h0);
        n++;
      end
      wrx(n);
      repeat (4) @(negedge ref_clk);
      chk(n_st, 2);
    end
    // Timer reload 3 in burst mode: no write before 512 clocks, then a write.
    rg(TXDQ_ADDR_FLUSH_TMR, 1'h1, 16'h0003, q);
    rg(TXDQ_ADDR_QCTRL, 1'h1, 16'h0008, q);
    for (int k = 0; k < 2; k++) begin
      push(1'h1, 1'h1, 3'h0);
      push(1'h1, 1'h1, 3'h0);
      n += 2;
      repeat (480) @(negedge ref_clk);
      chk({16'h0, rx_cnt}, 32'(n - 2));
      wrx(n);
    end
    // Longest reload: high water at six, then a forced flush.
    rg(TXDQ_ADDR_QCTRL, 1'h1, 16'h0000, q);
    rg(TXDQ_ADDR_FLUSH_TMR, 1'h1, 16'hffff, q);
    rg(TXDQ_ADDR_QCTRL, 1'h1, 16'h0008, q);
    repeat (5) push(1'h1, 1'h1, 3'h0);
    repeat (50) @(negedge ref_clk);
    chk({16'h0, rx_cnt}, 32'(n));
    n_ls = 0;
    push(1'h1, 1'h1, 3'h0);
    n += 6;
    wrx(n);
    chk(n_ls, 1);
    push(1'h1, 1'h1, 3'h0);
    push(1'h1, 1'h1, 3'h0);
    n += 2;
    repeat (50) @(negedge ref_clk);
    chk({16'h0, rx_cnt}, 32'(n - 2));
    rg(TXDQ_ADDR_QCTRL, 1'h1, 16'h0018, q);
    wrx(n);
    chk(n_ls, 2);
    rg(TXDQ_ADDR_QCTRL, 1'h1, 16'h0008, q);
    end_sim();
  end
endmodule
